// ### rtl/serial_pin_pkg.sv
// Purpose: constants and carriers for the serial port pin control block
// Assumes: 32-bit APB, one aligned word per register
// Notes:   16-bit pin control register sits in the low half of its word
package serial_pin_pkg;

  localparam logic [11:0] PIN_CONTROL_ADDR  = 12'h000;
  localparam logic [11:0] PORT_CONTROL_ADDR = 12'h004;
  localparam logic [11:0] GEN_CONFIG_ADDR   = 12'h008;

  localparam logic [15:0] PIN_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] PIN_CONTROL_WMASK = 16'h3FFF;

  localparam int TX_GPIO_EN_BIT    = 13;
  localparam int RX_GPIO_EN_BIT    = 12;
  localparam int TX_SYNC_MODE_BIT  = 11;
  localparam int RX_SYNC_MODE_BIT  = 10;
  localparam int TX_CLK_MODE_BIT   = 9;
  localparam int RX_CLK_MODE_BIT   = 8;
  localparam int GEN_REF_EXT_BIT   = 7;
  localparam int SCLK_STATE_BIT    = 6;
  localparam int TX_DATA_STATE_BIT = 5;
  localparam int RX_DATA_STATE_BIT = 4;
  localparam int TX_SYNC_POL_BIT   = 3;
  localparam int RX_SYNC_POL_BIT   = 2;
  localparam int TX_CLK_POL_BIT    = 1;
  localparam int RX_CLK_POL_BIT    = 0;

  // port control word: bit0 transmitter_reset_n, bit1 receiver_reset_n
  localparam int TX_RESET_N_BIT = 0;
  localparam int RX_RESET_N_BIT = 1;
  localparam logic [1:0] PORT_CONTROL_RESET = 2'h0;
  // generator config word: bit0 generator_sync_mode, bit1 generator_clock_sync,
  // bit2 generator internal clock select
  localparam int GEN_SYNC_MODE_BIT  = 0;
  localparam int GEN_CLK_SYNC_BIT   = 1;
  localparam int GEN_CLK_SELECT_BIT = 2;
  localparam logic [2:0] GEN_CONFIG_RESET = 3'h0;

  typedef enum logic [1:0] {
    REF_SAMPLE_PIN,
    REF_CPU,
    REF_RX_CLOCK,
    REF_TX_CLOCK
  } ref_select_t;

  typedef struct packed {
    logic tx_clock;
    logic tx_sync;
    logic tx_data;
  } tx_pins_t;

  typedef struct packed {
    logic sample_clock;
    logic rx_clock;
    logic rx_sync;
    logic rx_data;
  } rx_pins_t;

  // serial engine view of the pins, sync polarity already applied
  typedef struct packed {
    logic tx_clock;
    logic tx_sync;
    logic rx_clock;
    logic rx_sync;
    logic rx_data;
  } core_in_t;

endpackage : serial_pin_pkg

// ### rtl/serial_port_pin_control.sv
// Purpose: pin control register and pin muxing for one buffered serial port
// Assumes: pins are asynchronous to pclk and pass two flops before use
// Notes:   output enables are low while the block drives a pin
//
// What this block does
// - transmit gpio only while transmitter in reset
// - transmit gpio: data out, sync and clock gpio
// - receive gpio only while receiver in reset
// - receive gpio: data, sample clock in; sync, clock gpio
// - sample clock role from reset and receive gpio
// - transmit sync external or generator sync mode
// - receive sync external or generator output, unless clock sync
// - transmit clock mode: input external, output generator
// - generator reference may be transmit or receive clock
// - two top bits reserved, read zero
// - sync polarity: 0 active high, 1 active low
// - receive clock polarity chooses sampling edge
// - extend bit picks pin/cpu or rx/tx clock
// - receive data status shows pin in gpio input
`timescale 1ns/1ps
`default_nettype none

module serial_port_pin_control (
  input  wire  logic                      pclk,
  input  wire  logic                      presetn,
  input  wire  logic                      psel,
  input  wire  logic                      penable,
  input  wire  logic                      pwrite,
  input  wire  logic [11:0]               paddr,
  input  wire  logic [31:0]               pwdata,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire  serial_pin_pkg::tx_pins_t  tx_pin_in,
  output serial_pin_pkg::tx_pins_t        tx_pin_out,
  output serial_pin_pkg::tx_pins_t        tx_pin_oe_n,
  input  wire  serial_pin_pkg::rx_pins_t  rx_pin_in,
  output serial_pin_pkg::rx_pins_t        rx_pin_out,
  output serial_pin_pkg::rx_pins_t        rx_pin_oe_n,
  input  wire  logic                      core_tx_data,
  input  wire  logic                      core_tx_sync,
  input  wire  logic                      core_rx_sync,
  input  wire  logic                      gen_clock,
  output serial_pin_pkg::core_in_t        core_in,
  output logic                            core_rx_sample_rising,
  output logic                            core_tx_clock_polarity,
  output serial_pin_pkg::ref_select_t     gen_ref_select,
  output logic                            gen_ref_clock,
  output logic                            transmitter_reset_n,
  output logic                            receiver_reset_n
);

  logic [15:0] pin_control_r, pin_control_nxt;
  logic [1:0]  port_control_r, port_control_nxt;
  logic [2:0]  gen_config_r, gen_config_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic [6:0]  sync1_r, sync2_r;
  serial_pin_pkg::tx_pins_t tx_out_r, tx_out_nxt, tx_oe_r, tx_oe_nxt;
  serial_pin_pkg::rx_pins_t rx_out_r, rx_out_nxt, rx_oe_r, rx_oe_nxt;

  logic tx_gpio;
  logic rx_gpio;
  logic wr_en;
  logic rd_en;
  // synchronised pin levels
  logic s_tx_clk;
  logic s_tx_sync;
  logic s_rx_clk;
  logic s_rx_sync;
  logic s_rx_data;
  logic s_sclk;
  logic s_tx_data;

  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_PIN_CONTROL,
    SEL_PORT_CONTROL,
    SEL_GEN_CONFIG
  } reg_sel_t;

  reg_sel_t reg_sel;

  function automatic logic bitof(input logic [15:0] w, input int b);
    return w[b];
  endfunction : bitof

  // one decode shared by write and read paths, so both always agree
  function automatic reg_sel_t decode(input logic [11:0] a);
    reg_sel_t s;
    if (a == serial_pin_pkg::PIN_CONTROL_ADDR) begin
      s = SEL_PIN_CONTROL;
    end else if (a == serial_pin_pkg::PORT_CONTROL_ADDR) begin
      s = SEL_PORT_CONTROL;
    end else if (a == serial_pin_pkg::GEN_CONFIG_ADDR) begin
      s = SEL_GEN_CONFIG;
    end else begin
      s = SEL_NONE;
    end
    return s;
  endfunction : decode

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 7'h00;
      sync2_r <= 7'h00;
    end else begin
      sync1_r <= {tx_pin_in.tx_data, tx_pin_in.tx_clock, tx_pin_in.tx_sync,
                  rx_pin_in.sample_clock, rx_pin_in.rx_clock,
                  rx_pin_in.rx_sync, rx_pin_in.rx_data};
      sync2_r <= sync1_r;
    end
  end

  assign s_tx_data = sync2_r[6];
  assign s_tx_clk  = sync2_r[5];
  assign s_tx_sync = sync2_r[4];
  assign s_sclk    = sync2_r[3];
  assign s_rx_clk  = sync2_r[2];
  assign s_rx_sync = sync2_r[1];
  assign s_rx_data = sync2_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign reg_sel = decode(paddr);
  assign prdata  = prdata_r;

  assign transmitter_reset_n = port_control_r[serial_pin_pkg::TX_RESET_N_BIT];
  assign receiver_reset_n    = port_control_r[serial_pin_pkg::RX_RESET_N_BIT];
  assign tx_gpio = bitof(pin_control_r, serial_pin_pkg::TX_GPIO_EN_BIT)
                   && !transmitter_reset_n;
  assign rx_gpio = bitof(pin_control_r, serial_pin_pkg::RX_GPIO_EN_BIT)
                   && !receiver_reset_n;

  always_comb begin
    pin_control_nxt  = pin_control_r;
    port_control_nxt = port_control_r;
    gen_config_nxt   = gen_config_r;
    prdata_nxt       = prdata_r;
    // status bits follow pins in gpio input roles
    if (rx_gpio) begin
      pin_control_nxt[serial_pin_pkg::RX_DATA_STATE_BIT] = s_rx_data;
      pin_control_nxt[serial_pin_pkg::SCLK_STATE_BIT]    = s_sclk;
    end
    if (wr_en) begin
      if (reg_sel == SEL_PIN_CONTROL) begin
        // status bits of input roles are not writable while pins own them
        pin_control_nxt = pwdata[15:0] & serial_pin_pkg::PIN_CONTROL_WMASK;
        if (rx_gpio) begin
          pin_control_nxt[serial_pin_pkg::RX_DATA_STATE_BIT] = s_rx_data;
          pin_control_nxt[serial_pin_pkg::SCLK_STATE_BIT]    = s_sclk;
        end
      end else if (reg_sel == SEL_PORT_CONTROL) begin
        port_control_nxt = pwdata[1:0];
      end else if (reg_sel == SEL_GEN_CONFIG) begin
        gen_config_nxt = pwdata[2:0];
      end
    end
    if (rd_en) begin
      if (reg_sel == SEL_PIN_CONTROL) begin
        prdata_nxt = {16'h0000, pin_control_r};
      end else if (reg_sel == SEL_PORT_CONTROL) begin
        prdata_nxt = {30'h00000000, port_control_r};
      end else if (reg_sel == SEL_GEN_CONFIG) begin
        prdata_nxt = {29'h00000000, gen_config_r};
      end else begin
        prdata_nxt = 32'h00000000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_control_r  <= serial_pin_pkg::PIN_CONTROL_RESET;
      port_control_r <= serial_pin_pkg::PORT_CONTROL_RESET;
      gen_config_r   <= serial_pin_pkg::GEN_CONFIG_RESET;
      prdata_r       <= 32'h00000000;
    end else begin
      pin_control_r  <= pin_control_nxt;
      port_control_r <= port_control_nxt;
      gen_config_r   <= gen_config_nxt;
      prdata_r       <= prdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin direction and drive
  logic tx_sync_pol, rx_sync_pol, tx_sync_int, rx_sync_out;
  assign tx_sync_pol = bitof(pin_control_r, serial_pin_pkg::TX_SYNC_POL_BIT);
  assign rx_sync_pol = bitof(pin_control_r, serial_pin_pkg::RX_SYNC_POL_BIT);
  // transmit sync from generator only when generator sync mode chosen
  assign tx_sync_int = bitof(pin_control_r, serial_pin_pkg::TX_SYNC_MODE_BIT)
                       && gen_config_r[serial_pin_pkg::GEN_SYNC_MODE_BIT];
  assign rx_sync_out = bitof(pin_control_r, serial_pin_pkg::RX_SYNC_MODE_BIT)
                       && !gen_config_r[serial_pin_pkg::GEN_CLK_SYNC_BIT];

  always_comb begin
    tx_out_nxt = '0;
    tx_oe_nxt  = '1;
    rx_out_nxt = '0;
    rx_oe_nxt  = '1;
    if (tx_gpio) begin
      // gpio directions follow the serial mode bits; data always drives
      tx_out_nxt.tx_data  = bitof(pin_control_r, serial_pin_pkg::TX_DATA_STATE_BIT);
      tx_oe_nxt.tx_data   = 1'b0;
      tx_out_nxt.tx_sync  = tx_sync_pol;
      tx_oe_nxt.tx_sync   = !bitof(pin_control_r, serial_pin_pkg::TX_SYNC_MODE_BIT);
      tx_out_nxt.tx_clock = bitof(pin_control_r, serial_pin_pkg::TX_CLK_POL_BIT);
      tx_oe_nxt.tx_clock  = !bitof(pin_control_r, serial_pin_pkg::TX_CLK_MODE_BIT);
    end else begin
      tx_out_nxt.tx_data  = core_tx_data;
      tx_oe_nxt.tx_data   = 1'b0;
      tx_out_nxt.tx_sync  = core_tx_sync ^ tx_sync_pol;
      tx_oe_nxt.tx_sync   = !tx_sync_int;
      tx_out_nxt.tx_clock = gen_clock;
      tx_oe_nxt.tx_clock  = !bitof(pin_control_r, serial_pin_pkg::TX_CLK_MODE_BIT);
    end
    if (rx_gpio) begin
      // data and sample clock stay inputs; sync and clock by mode bits
      rx_out_nxt.rx_sync  = rx_sync_pol;
      rx_oe_nxt.rx_sync   = !bitof(pin_control_r, serial_pin_pkg::RX_SYNC_MODE_BIT);
      rx_out_nxt.rx_clock = bitof(pin_control_r, serial_pin_pkg::RX_CLK_POL_BIT);
      rx_oe_nxt.rx_clock  = !bitof(pin_control_r, serial_pin_pkg::RX_CLK_MODE_BIT);
    end else begin
      rx_out_nxt.rx_sync  = core_rx_sync ^ rx_sync_pol;
      rx_oe_nxt.rx_sync   = !rx_sync_out;
      rx_out_nxt.rx_clock = gen_clock;
      rx_oe_nxt.rx_clock  = !bitof(pin_control_r, serial_pin_pkg::RX_CLK_MODE_BIT);
    end
    rx_oe_nxt.sample_clock = 1'b1;
    rx_oe_nxt.rx_data      = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_out_r <= '0;
      tx_oe_r  <= '1;
      rx_out_r <= '0;
      rx_oe_r  <= '1;
    end else begin
      tx_out_r <= tx_out_nxt;
      tx_oe_r  <= tx_oe_nxt;
      rx_out_r <= rx_out_nxt;
      rx_oe_r  <= rx_oe_nxt;
    end
  end

  assign tx_pin_out  = tx_out_r;
  assign tx_pin_oe_n = tx_oe_r;
  assign rx_pin_out  = rx_out_r;
  assign rx_pin_oe_n = rx_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // serial engine view and generator reference
  serial_pin_pkg::core_in_t core_in_r, core_in_nxt;
  serial_pin_pkg::ref_select_t ref_sel;
  logic ref_clk_r, ref_clk_nxt;

  always_comb begin
    core_in_nxt = '0;
    // gpio roles feed the engine nothing; it is held in reset anyway
    if (!tx_gpio) begin
      core_in_nxt.tx_clock = s_tx_clk;
      core_in_nxt.tx_sync  = s_tx_sync ^ tx_sync_pol;
    end
    if (!rx_gpio) begin
      core_in_nxt.rx_clock = s_rx_clk;
      core_in_nxt.rx_sync  = s_rx_sync ^ rx_sync_pol;
      core_in_nxt.rx_data  = s_rx_data;
    end
    ref_sel = serial_pin_pkg::ref_select_t'({
      bitof(pin_control_r, serial_pin_pkg::GEN_REF_EXT_BIT),
      gen_config_r[serial_pin_pkg::GEN_CLK_SELECT_BIT]});
    case (ref_sel)
      serial_pin_pkg::REF_SAMPLE_PIN: ref_clk_nxt = rx_gpio ? 1'b0 : s_sclk;
      serial_pin_pkg::REF_CPU:        ref_clk_nxt = 1'b0;
      serial_pin_pkg::REF_RX_CLOCK:   ref_clk_nxt = s_rx_clk;
      default:                        ref_clk_nxt = s_tx_clk;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_in_r <= '0;
      ref_clk_r <= 1'b0;
    end else begin
      core_in_r <= core_in_nxt;
      ref_clk_r <= ref_clk_nxt;
    end
  end

  assign core_in                = core_in_r;
  assign gen_ref_clock          = ref_clk_r;
  assign gen_ref_select         = ref_sel;
  assign core_rx_sample_rising  = bitof(pin_control_r, serial_pin_pkg::RX_CLK_POL_BIT);
  assign core_tx_clock_polarity = bitof(pin_control_r, serial_pin_pkg::TX_CLK_POL_BIT);

  logic unused_ok;
  assign unused_ok = s_tx_data;

endmodule : serial_port_pin_control

`default_nettype wire

// ### verification/serial_far_end.sv
// Purpose: far side serial device, resolves pin levels
// Assumes: link clock runs only while link_run is high
// Notes:   released outputs of the block show a changing pattern
`timescale 1ns/1ps
`default_nettype none
module serial_far_end (
  input  wire serial_pin_pkg::tx_pins_t tx_pin_out,
  input  wire serial_pin_pkg::tx_pins_t tx_pin_oe_n,
  input  wire serial_pin_pkg::rx_pins_t rx_pin_out,
  input  wire serial_pin_pkg::rx_pins_t rx_pin_oe_n,
  input  wire logic                     link_run,
  input  wire logic                     data_lvl,
  input  wire logic                     sync_lvl,
  output serial_pin_pkg::tx_pins_t      tx_pin_in,
  output serial_pin_pkg::rx_pins_t      rx_pin_in
);
  logic                     link_clk = 1'b0;
  serial_pin_pkg::tx_pins_t far_tx;
  serial_pin_pkg::rx_pins_t far_rx;
  always #40 link_clk = link_run ? ~link_clk : 1'b0;
  assign far_tx = '{tx_clock: link_clk, tx_sync: sync_lvl, tx_data: ~link_clk};
  assign far_rx = '{sample_clock: data_lvl, rx_clock: link_clk, rx_sync: sync_lvl,
                    rx_data: data_lvl};
  assign tx_pin_in = (tx_pin_out & ~tx_pin_oe_n) | (far_tx & tx_pin_oe_n);
  assign rx_pin_in = (rx_pin_out & ~rx_pin_oe_n) | (far_rx & rx_pin_oe_n);
endmodule : serial_far_end
`default_nettype wire

// ### verification/serial_port_pin_control_sva.sv
// Purpose: port checks for the serial pin control block
// Assumes: registers shadowed from observed apb writes
// Notes:   pin outputs lag the register by one cycle
`timescale 1ns/1ps
`default_nettype none
module pin_control_checker (
  input wire logic                          pclk,
  input wire logic                          presetn,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [11:0]                   paddr,
  input wire logic [31:0]                   pwdata,
  input wire logic [31:0]                   prdata,
  input wire serial_pin_pkg::tx_pins_t      tx_pin_out,
  input wire serial_pin_pkg::tx_pins_t      tx_pin_oe_n,
  input wire serial_pin_pkg::rx_pins_t      rx_pin_oe_n,
  input wire serial_pin_pkg::ref_select_t   gen_ref_select,
  input wire logic                          core_rx_sample_rising,
  input wire logic                          transmitter_reset_n,
  input wire logic                          receiver_reset_n
);
  logic [15:0] pc_r, pc_nxt;
  logic [2:0]  gc_r, gc_nxt;
  wire logic   wr = psel && penable && pwrite;
  wire logic   g_tx = pc_r[13] && !transmitter_reset_n;
  wire logic   g_rx = pc_r[12] && !receiver_reset_n;
  wire logic   ts = pc_r[11] && gc_r[0];
  wire logic   rs = pc_r[10] && !gc_r[1];
  always_comb begin
    pc_nxt = pc_r;
    gc_nxt = gc_r;
    if (wr && paddr == 12'h000) pc_nxt = pwdata[15:0] & 16'h3FFF;
    if (wr && paddr == 12'h008) gc_nxt = pwdata[2:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r <= 16'h0000;
      gc_r <= 3'h0;
    end else begin
      pc_r <= pc_nxt;
      gc_r <= gc_nxt;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_tx_gpio; g_tx |=> !tx_pin_oe_n.tx_data && tx_pin_out.tx_data == $past(pc_r[5]);
  endproperty
  a_tx_gpio: assert property (p_tx_gpio) else $error("gpio data pin wrong");
  property p_tx_clk_in; !pc_r[9] |=> tx_pin_oe_n.tx_clock; endproperty
  a_tx_clk_in: assert property (p_tx_clk_in) else $error("tx clock not input");
  property p_tx_clk_gp; g_tx && pc_r[9] |=> tx_pin_out.tx_clock == $past(pc_r[1]); endproperty
  a_tx_clk_gp: assert property (p_tx_clk_gp) else $error("gpio clock level wrong");
  property p_tx_sync; !g_tx |=> tx_pin_oe_n.tx_sync == $past(!ts); endproperty
  a_tx_sync: assert property (p_tx_sync) else $error("tx sync direction wrong");
  property p_rx_sync; !g_rx |=> rx_pin_oe_n.rx_sync == $past(!rs); endproperty
  a_rx_sync: assert property (p_rx_sync) else $error("rx sync direction wrong");
  property p_rx_in; rx_pin_oe_n.rx_data && rx_pin_oe_n.sample_clock; endproperty
  a_rx_in: assert property (p_rx_in) else $error("rx input driven");
  property p_ref; gen_ref_select == {pc_r[7], gc_r[2]}; endproperty
  a_ref: assert property (p_ref) else $error("reference select wrong");
  property p_rx_edge; core_rx_sample_rising == pc_r[0]; endproperty
  a_rx_edge: assert property (p_rx_edge) else $error("rx sample edge wrong");
  property p_rsvd; psel && penable && !pwrite |-> prdata[31:14] == 18'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  c_tx_gpio: cover property (g_tx);
  c_rx_gpio: cover property (g_rx);
  c_ref_tx: cover property (gen_ref_select == serial_pin_pkg::REF_TX_CLOCK);
endmodule : pin_control_checker
bind serial_port_pin_control pin_control_checker u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .tx_pin_out, .tx_pin_oe_n, .rx_pin_oe_n,
  .gen_ref_select, .core_rx_sample_rising, .transmitter_reset_n, .receiver_reset_n);
`default_nettype wire

// ### verification/tb_serial_port_pin_control.sv
// Purpose: self-checking bench for the serial pin control block
// Assumes: pready answers within 20 cycles
// Notes:   register rows first, then hand-written cases
`timescale 1ns/1ps
`default_nettype none
module tb_serial_port_pin_control;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] e;} row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic core_tx_data, link_run, data_lvl, sync_lvl, transmitter_reset_n, receiver_reset_n;
  logic core_tx_sync, core_rx_sync, gen_clock, gen_ref_clock, prev_c, prev_r;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  serial_pin_pkg::tx_pins_t tx_pin_in, tx_pin_out, tx_pin_oe_n;
  serial_pin_pkg::rx_pins_t rx_pin_in, rx_pin_out, rx_pin_oe_n;
  serial_pin_pkg::core_in_t core_in;
  serial_pin_pkg::ref_select_t gen_ref_select;
  int mismatches, compares, n, nr;
  row_t rows[6] = '{'{12'h000, 32'hFFFF_EFFF, 32'h0000_2FFF}, '{12'h000, 32'h0000_AAAA,
    32'h0000_2AAA}, '{12'h004, 32'hFFFF_FFFF, 32'h0000_0003}, '{12'h008, 32'hFFFF_FFFF,
    32'h0000_0007}, '{12'h00C, 32'hFFFF_FFFF, 32'h0000_0000}, '{12'h008, 32'h0, 32'h0}};
  serial_port_pin_control u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .tx_pin_in, .tx_pin_out, .tx_pin_oe_n, .rx_pin_in,
    .rx_pin_out, .rx_pin_oe_n, .core_tx_data, .core_tx_sync, .core_rx_sync,
    .gen_clock, .core_in, .core_rx_sample_rising(), .core_tx_clock_polarity(),
    .gen_ref_select, .gen_ref_clock, .transmitter_reset_n, .receiver_reset_n);
  serial_far_end u_far (.tx_pin_out, .tx_pin_oe_n, .rx_pin_out, .rx_pin_oe_n, .link_run,
    .data_lvl, .sync_lvl, .tx_pin_in, .rx_pin_in);
  //////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd_v = prdata;
    if (pready !== 1'b1) begin
      mismatches++;
      results();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic settle;
    repeat (5) @(posedge pclk);
  endtask : settle
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, core_tx_data, link_run, data_lvl, sync_lvl} = '0;
    {core_tx_sync, core_rx_sync, gen_clock} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    mismatches = 0;
    compares = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 32'h0);
      chk("register row", rows[i].e, rd_v);
    end
    apb(1'b1, 12'h004, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h000, {24'h0, i[1], 7'h0});
      apb(1'b1, 12'h008, {29'h0, i[0], 2'h0});
      settle();
      chk("reference select", i, {30'h0, gen_ref_select});
    end
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h000, 32'h0000_1000);
    for (int v = 0; v < 2; v++) begin
      data_lvl <= v[0];
      settle();
      apb(1'b0, 12'h000, 32'h0);
      chk("receive pin status", 32'h0000_1000 | (v * 32'h50), rd_v);
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h000, {29'h0, i[1], 2'h0});
      sync_lvl <= i[0];
      settle();
      chk("receive sync to core", i[0] ^ i[1], {31'h0, core_in.rx_sync});
    end
    apb(1'b1, 12'h000, 32'h0000_2020);
    settle();
    chk("gpio data pin", 32'h1, {30'h0, tx_pin_oe_n.tx_data, tx_pin_out.tx_data});
    apb(1'b1, 12'h004, 32'h1);
    settle();
    chk("serial data pin", 32'h0, {31'h0, tx_pin_out.tx_data});
    apb(1'b1, 12'h004, 32'h3);
    apb(1'b1, 12'h000, 32'h0000_1000);
    settle();
    apb(1'b0, 12'h000, 32'h0);
    chk("status outside gpio", 32'h0000_1000, rd_v);
    gen_clock <= 1'b1;
    apb(1'b1, 12'h000, 32'h0000_0200);
    settle();
    chk("gen clock pin", 32'h1, {30'h0, tx_pin_oe_n.tx_clock, tx_pin_out.tx_clock});
    core_tx_sync <= 1'b1;
    core_rx_sync <= 1'b1;
    apb(1'b1, 12'h008, 32'h3);
    apb(1'b1, 12'h000, 32'h0000_0C08);
    settle();
    chk("gen sync pin", 32'h0, {30'h0, tx_pin_oe_n.tx_sync, tx_pin_out.tx_sync});
    chk("rx sync clock sync", 32'h1, {31'h0, rx_pin_oe_n.rx_sync});
    apb(1'b1, 12'h008, 32'h1);
    settle();
    chk("rx sync gen pin", 32'h1, {30'h0, rx_pin_oe_n.rx_sync, rx_pin_out.rx_sync});
    apb(1'b1, 12'h008, 32'h4);
    apb(1'b1, 12'h000, 32'h0000_0080);
    link_run <= 1'b1;
    settle();
    n = 0;
    nr = 0;
    prev_c = core_in.tx_clock;
    prev_r = gen_ref_clock;
    repeat (100) begin
      @(posedge pclk);
      if (core_in.tx_clock !== prev_c) n++;
      if (gen_ref_clock !== prev_r) nr++;
      prev_c = core_in.tx_clock;
      prev_r = gen_ref_clock;
    end
    link_run <= 1'b0;
    chk("link clock edges", 32'h1, {31'h0, (n >= 20 && n <= 26)});
    chk("reference clock edges", 32'h1, {31'h0, (nr >= 20 && nr <= 26)});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk("pin control after reset", 32'h0, rd_v);
    apb(1'b0, 12'h004, 32'h0);
    chk("port control after reset", 32'h0, rd_v);
    chk("rx pins released", 32'hF, {28'h0, rx_pin_oe_n});
    results();
  end
endmodule : tb_serial_port_pin_control
`default_nettype wire
